// ### inc/sac_pkg.sv
// Constants shared by the conversion sequencer and its result memory
package sac_pkg;
  localparam int unsigned CH_COUNT     = 8;
  localparam int unsigned CH_IDX_W     = 3;
  localparam int unsigned RES_W        = 12;
  localparam int unsigned CFG_W        = 8;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'hff;

  // Conversion timing in conversion-clock ticks
  localparam int unsigned TICK_W       = 4;
  localparam logic [TICK_W-1:0] FIRST_TICKS = 4'hc;
  localparam logic [TICK_W-1:0] NEXT_TICKS  = 4'h3;

  // Internal conversion clock derived from sys_clk
  localparam int unsigned SYS_FREQ_KHZ = 250000;
  localparam int unsigned INT_FREQ_KHZ = 15000;
  localparam int unsigned INT_DIV      = (SYS_FREQ_KHZ + INT_FREQ_KHZ / 2) / INT_FREQ_KHZ;
  localparam int unsigned DIV_W        = 5;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_DIV - 1);

  // Longest internal-clock latencies and their cycle budgets (round down)
  localparam int unsigned SYS_PERIOD_PS  = 4000;
  localparam int unsigned FIRST_MAX_NS   = 900;
  localparam int unsigned NEXT_MAX_NS    = 225;
  localparam int unsigned FIRST_MAX_CYC  = FIRST_MAX_NS * 1000 / SYS_PERIOD_PS;
  localparam int unsigned NEXT_MAX_CYC   = NEXT_MAX_NS * 1000 / SYS_PERIOD_PS;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b01,
    SAC_CONV = 2'b10
  } sac_state_e;
endpackage

// ### rtl/sac_result_mem.sv
// Result store: one word per converted channel, registered read data
`timescale 1ns/100ps
module sac_result_mem (
  input  wire logic                           sys_clk,
  input  wire logic                           rstn,
  input  wire logic                           wr_en,
  input  wire logic [sac_pkg::CH_IDX_W-1:0]   wr_addr,
  input  wire logic [sac_pkg::RES_W-1:0]      wr_data,
  input  wire logic [sac_pkg::CH_IDX_W-1:0]   rd_addr,
  output logic      [sac_pkg::RES_W-1:0]      rd_data
);
  logic [sac_pkg::RES_W-1:0] mem [sac_pkg::CH_COUNT];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // sac_result_mem

// ### rtl/sac_sequencer.sv
// Simultaneous-sampling conversion sequencer with parallel result bus
//
// Overview of operation
// - First result 12 ticks, internal under 900ns
// - Further results every 3 ticks, internal under 225ns
// - Chip select ANDed with each strobe
// - Internal clock near 15MHz ignores external clock
// - Conversion logic acts on external rising edges
// - Conversion flag driven from clock rising edge
// - Last-done flag falls after final conversion
// - Last-done flag rises when start falls; stays low if start falls on the final conversion tick
// - Data bus released when read or select high
// - Only lower eight lines accept input data
// - Throughput scales with conversion clock rate
// - All channels sampled on start rising edge
// - Conversion flag low, back high next tick
// - Write strobe loads channel select from bus
// - Read strobe drives a result onto bus
`timescale 1ns/100ps
module sac_sequencer (
  input  wire logic                                       sys_clk,
  input  wire logic                                       rstn,
  input  wire logic                                       convert_start,
  input  wire logic                                       ext_clk,
  input  wire logic                                       clock_source_select,
  input  wire logic [sac_pkg::CH_COUNT*sac_pkg::RES_W-1:0] sample_data,
  input  wire logic                                       cs_n,
  input  wire logic                                       rd_n,
  input  wire logic                                       wr_n,
  input  wire logic [sac_pkg::CFG_W-1:0]                  d_in,
  output logic      [sac_pkg::RES_W-1:0]                  d_out,
  output logic                                            d_oe,
  output logic                                            conv_done_n,
  output logic                                            last_conversion_done_flag,
  output logic      [sac_pkg::CFG_W-1:0]                  channel_select
);
  sac_pkg::sac_state_e                  state, next_state;
  logic                                 start_q, next_start_q;
  logic                                 ext_q, next_ext_q;
  logic                                 rd_q, next_rd_q;
  logic [sac_pkg::DIV_W-1:0]            div_cnt, next_div_cnt;
  logic [sac_pkg::TICK_W-1:0]           tick_cnt, next_tick_cnt;
  logic [sac_pkg::TICK_W-1:0]           target, next_target;
  logic [sac_pkg::CH_IDX_W-1:0]         chan, next_chan;
  logic [sac_pkg::CH_IDX_W-1:0]         wr_idx, next_wr_idx;
  logic [sac_pkg::CH_IDX_W-1:0]         rd_ptr, next_rd_ptr;
  logic [sac_pkg::CFG_W-1:0]            next_channel_select;
  logic [sac_pkg::CH_COUNT*sac_pkg::RES_W-1:0] held, next_held;
  logic                                 next_conv_done_n, next_last_done;
  logic                                 start_rise, start_fall, ext_rise, int_tick, tick;
  logic                                 wr_act, rd_act;
  logic                                 mem_we;
  logic [sac_pkg::CH_IDX_W:0]           found;
  logic                                 seq_go;

  // Lowest selected channel at or above a starting index; top bit = found
  function automatic logic [sac_pkg::CH_IDX_W:0] find_sel(
    input logic [sac_pkg::CFG_W-1:0] sel,
    input logic [sac_pkg::CH_IDX_W:0] from
  );
    logic [sac_pkg::CH_IDX_W:0] res;
    res = '0;
    for (int i = sac_pkg::CH_COUNT - 1; i >= 0; i--) begin
      if (sel[i] && (i >= int'(from))) begin
        res = {1'b1, sac_pkg::CH_IDX_W'(i)};
      end
    end
    return res;
  endfunction

  assign wr_act     = ~cs_n & ~wr_n;
  assign rd_act     = ~cs_n & ~rd_n;
  assign d_oe       = rd_act;
  assign start_rise = convert_start & ~start_q;
  assign start_fall = ~convert_start & start_q;
  assign ext_rise   = ext_clk & ~ext_q;
  assign int_tick   = (div_cnt == sac_pkg::DIV_LAST);
  // Internal mode ignores the external clock pin
  assign tick       = clock_source_select ? int_tick : ext_rise;
  assign seq_go     = (state == sac_pkg::SAC_IDLE) && start_rise;

  always_comb begin
    next_state          = state;
    next_tick_cnt       = tick_cnt;
    next_target         = target;
    next_chan           = chan;
    next_wr_idx         = wr_idx;
    next_held           = held;
    next_conv_done_n    = conv_done_n;
    next_last_done      = last_conversion_done_flag;
    mem_we              = 1'b0;
    found               = '0;

    if (tick) begin
      next_conv_done_n = 1'b1;
    end
    if (start_fall) begin
      next_conv_done_n = 1'b1;
      next_last_done   = 1'b1;
    end

    case (state)
      sac_pkg::SAC_IDLE: begin
        if (start_rise) begin
          next_held     = sample_data;
          next_tick_cnt = '0;
          next_target   = sac_pkg::FIRST_TICKS;
          found         = find_sel(channel_select, '0);
          next_chan     = found[sac_pkg::CH_IDX_W-1:0];
          next_wr_idx   = '0;
          next_state    = sac_pkg::SAC_CONV;
        end
      end
      sac_pkg::SAC_CONV: begin
        if (tick) begin
          next_tick_cnt = tick_cnt + 1'b1;
          if (next_tick_cnt == target) begin
            mem_we           = channel_select[chan];
            next_wr_idx      = wr_idx + 1'b1;
            next_conv_done_n = 1'b0;
            next_tick_cnt    = '0;
            next_target      = sac_pkg::NEXT_TICKS;
            found            = find_sel(channel_select, {1'b0, chan} + 1'b1);
            next_chan        = found[sac_pkg::CH_IDX_W-1:0];
            if (!found[sac_pkg::CH_IDX_W]) begin
              next_last_done = 1'b0;
              next_state     = sac_pkg::SAC_IDLE;
            end
          end
        end
      end
      default: next_state = sac_pkg::SAC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state                     <= sac_pkg::SAC_IDLE;
      tick_cnt                  <= '0;
      target                    <= sac_pkg::FIRST_TICKS;
      chan                      <= '0;
      wr_idx                    <= '0;
      held                      <= '0;
      conv_done_n               <= 1'b1;
      last_conversion_done_flag <= 1'b1;
    end else begin
      state                     <= next_state;
      tick_cnt                  <= next_tick_cnt;
      target                    <= next_target;
      chan                      <= next_chan;
      wr_idx                    <= next_wr_idx;
      held                      <= next_held;
      conv_done_n               <= next_conv_done_n;
      last_conversion_done_flag <= next_last_done;
    end
  end

  // Pin history and internal conversion clock divider
  always_comb begin
    next_start_q = convert_start;
    next_ext_q   = ext_clk;
    next_rd_q    = rd_act;
    next_div_cnt = int_tick ? '0 : div_cnt + 1'b1;
    // Restart with each sequence so tick spacing is exact
    if (seq_go) begin
      next_div_cnt = '0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      start_q <= 1'b0;
      ext_q   <= 1'b0;
      rd_q    <= 1'b0;
      div_cnt <= '0;
    end else begin
      start_q <= next_start_q;
      ext_q   <= next_ext_q;
      rd_q    <= next_rd_q;
      div_cnt <= next_div_cnt;
    end
  end

  // Configuration byte and read pointer
  always_comb begin
    next_channel_select = channel_select;
    next_rd_ptr         = rd_ptr;
    if (wr_act) begin
      next_channel_select = d_in;
    end
    // Pointer restarts per sequence, steps at each read strobe end
    if (seq_go) begin
      next_rd_ptr = '0;
    end else if (rd_q && !rd_act) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      channel_select <= sac_pkg::CFG_RESET;
      rd_ptr         <= '0;
    end else begin
      channel_select <= next_channel_select;
      rd_ptr         <= next_rd_ptr;
    end
  end

  sac_result_mem u_mem (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wr_en   (mem_we),
    .wr_addr (wr_idx),
    .wr_data (held[chan*sac_pkg::RES_W +: sac_pkg::RES_W]),
    .rd_addr (rd_ptr),
    .rd_data (d_out)
  );
endmodule // sac_sequencer

// ### tb/sac_seq_props.sv
// Port assertions for the conversion sequencer
`timescale 1ns/100ps
module sac_seq_props (
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        convert_start,
  input wire logic        clock_source_select,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        wr_n,
  input wire logic [7:0]  d_in,
  input wire logic [11:0] d_out,
  input wire logic        d_oe,
  input wire logic        conv_done_n,
  input wire logic        last_conversion_done_flag,
  input wire logic [7:0]  channel_select
);
  localparam int F_LO = 180;
  localparam int F_HI = 216;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_int_go;
    clock_source_select && $rose(convert_start) && last_conversion_done_flag;
  endsequence
  sequence s_gap;
    $rose(conv_done_n) && last_conversion_done_flag && convert_start && clock_source_select;
  endsequence
  a_bus_and: assert property (d_oe == (!cs_n && !rd_n))
    else $error("bus enable wrong");
  a_cfg_load: assert property (!cs_n && !wr_n |=> channel_select == $past(d_in))
    else $error("config not loaded");
  a_cfg_keep: assert property (cs_n || wr_n |=> $stable(channel_select))
    else $error("config changed");
  a_first_int: assert property (s_int_go |-> ##1 conv_done_n [*8] ##[F_LO:F_HI] $fell(conv_done_n))
    else $error("first result late");
  a_next_int: assert property (s_gap |-> ##[1:56] $fell(conv_done_n))
    else $error("next result late");
  a_last_fall: assert property ($fell(last_conversion_done_flag) |-> $fell(conv_done_n))
    else $error("last flag alone");
  a_last_hold: assert property (!last_conversion_done_flag && convert_start |=> !last_conversion_done_flag)
    else $error("last flag rose early");
  a_start_fall: assert property ($fell(convert_start) |=> last_conversion_done_flag && conv_done_n)
    else $error("flags not released");
  a_read_hold: assert property (!cs_n && !rd_n && !$past(cs_n || rd_n) |-> $stable(d_out))
    else $error("read data moved");
endmodule // sac_seq_props

bind sac_sequencer sac_seq_props u_props (.sys_clk, .rstn, .convert_start, .clock_source_select,
  .cs_n, .rd_n, .wr_n, .d_in, .d_out, .d_oe, .conv_done_n, .last_conversion_done_flag,
  .channel_select);

// ### tb/sac_host_model.sv
// Host side: external conversion clock and resolved data bus
`timescale 1ns/100ps
module sac_host_model #(parameter realtime HALF = 25.0) (
  input  wire logic        run,
  input  wire logic [11:0] d_out,
  input  wire logic        d_oe,
  output logic             ext_clk,
  output logic [11:0]      d_bus
);
  logic [11:0] last_v = 12'h000;
  initial begin
    ext_clk = 1'b0;
    // Quarter-period offset keeps edges clear of sys_clk edges
    #(HALF / 2.0);
    forever begin
      #HALF ext_clk = run ? ~ext_clk : 1'b0;
    end
  end
  // Released bus shows the inverse of its last value
  always @* begin
    if (d_oe) last_v = d_out;
    d_bus = d_oe ? d_out : ~last_v;
  end
endmodule // sac_host_model

// ### tb/tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module tb_top;
  logic        sys_clk, rstn, convert_start, clock_source_select, cs_n, rd_n, wr_n;
  logic        run, ext_clk, d_oe, conv_done_n, last_f, prev;
  logic [95:0] sample_data;
  logic [7:0]  d_in, channel_select;
  logic [11:0] d_out, d_bus;
  logic [31:0] seed = 32'h0000_0060;
  logic [11:0] exp_q[$];
  logic [1:0]  rd_age = 2'h0;
  int          n_fail = 0, samples_checked = 0, ext_cnt = 0;
  sac_sequencer uut (.sys_clk, .rstn, .convert_start, .ext_clk, .clock_source_select,
    .sample_data, .cs_n, .rd_n, .wr_n, .d_in, .d_out, .d_oe, .conv_done_n,
    .last_conversion_done_flag(last_f), .channel_select);
  sac_host_model host (.run, .d_out, .d_oe, .ext_clk, .d_bus);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge ext_clk) ext_cnt++;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Oldest expected word against the bus on the last strobe cycle
  always @(posedge sys_clk) begin
    rd_age <= (!cs_n && !rd_n) ? rd_age + 2'h1 : 2'h0;
    if (rd_age == 2'h2) chk(d_bus, exp_q.pop_front(), "read");
  end
  task automatic strobe(input logic wr, input logic [7:0] v);
    cs_n <= 1'b0;
    rd_n <= wr;
    wr_n <= ~wr;
    d_in <= v;
    repeat (3) @(posedge sys_clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    d_in <= ~v;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic conv(input logic ext, input logic [7:0] sel);
    int i;
    int t0;
    int k;
    clock_source_select <= ~ext;
    sample_data <= {xs(), xs(), xs()};
    strobe(1'b1, sel);
    chk({4'h0, channel_select}, {4'h0, sel}, "config");
    repeat (30) @(posedge sys_clk);
    convert_start <= 1'b1;
    for (i = 0; i < 8; i++) if (sel[i]) exp_q.push_back(sample_data[12*i +: 12]);
    @(posedge sys_clk);
    sample_data <= ~sample_data;
    run <= 1'b1;
    t0 = ext_cnt;
    k = 0;
    prev = 1'b1;
    for (i = 0; last_f; i++) begin
      @(posedge sys_clk);
      if (i > 3000) begin
        n_fail++;
        $display("mismatch at %0t: sequence timed out", $time);
        test_done();
      end
      if (!conv_done_n && prev && ext) chk(12'(ext_cnt - t0), k ? 12'h3 : 12'hc, "ticks");
      if (!conv_done_n && prev) t0 = ext_cnt;
      if (!conv_done_n && prev) k = 1;
      prev = conv_done_n;
    end
    run <= 1'b0;
    repeat (5) @(posedge sys_clk);
    convert_start <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk({10'h0, last_f, conv_done_n}, 12'h3, "flags");
    for (i = 0; i < 8; i++) if (sel[i]) strobe(1'b0, 8'h00);
    $display("test end ext=%0d sel=%h", ext, sel);
  endtask
  initial begin
    {rstn, convert_start, run, d_in, sample_data} = '0;
    {clock_source_select, cs_n, rd_n, wr_n} = 4'hf;
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk({4'h0, channel_select}, 12'h0ff, "reset config");
    conv(1'b0, 8'h0a);
    conv(1'b1, 8'h81);
    conv(1'b1, 8'(xs()) | 8'h10);
    conv(1'b0, 8'hff);
    chk(12'(exp_q.size()), 12'h0, "leftover");
    test_done();
  end
endmodule // tb_top
